/* src/timer_pkg.sv */
// Function
// - Timer mode counts one per prescaled internal clock, ratio from prescale_select.
// - Counter runs only while counter_run_bit is set; starts at once except in pulse mode.
// - On overflow raise interrupt, reload from preload, keep counting, every mode.
// - Overflow interrupt reaches the core only while its enable bit is one.
// - Event mode counts external transitions and bypasses the prescaler.
// - Event mode counts rising edges when edge select low, falling when high.
// - Event mode keeps counting in power-down; overflow requests interrupt and wake-up.
// - Both mode bits one selects pulse width measurement mode.
// - Pulse mode: run bit only arms; counting starts on an active edge.
// - Pulse mode, edge select low: start on falling, stop and clear on rising.
// - Pulse mode, edge select high: start on rising, stop and clear on falling.
// - Outside pulse mode only software may clear the run bit.
// - After a measurement the count holds; edges ignored until run set again.
// - Pulse mode start and stop follow pin transitions, not pin levels.
// - Pull-high option on the shared pin stays active while used as timer input.
// - Counter counts up from preload to all ones, overflowing past all ones.
// - Preload write when stopped loads counter too; when running, waits for overflow.
`default_nettype none
package timer_pkg;
   localparam int unsigned COUNT_W_DEFAULT = 8;
   localparam int unsigned INT_W           = 2;
   localparam int unsigned PRESCALE_W      = 3;
   localparam int unsigned DIV_W           = 7;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL       = 8'h00;
   localparam logic [7:0] OFF_PRELOAD    = 8'h04;
   localparam logic [7:0] OFF_COUNT      = 8'h08;
   localparam logic [7:0] OFF_INT_STATUS = 8'h0c;
   localparam logic [7:0] OFF_INT_CLEAR  = 8'h10;
   localparam logic [7:0] OFF_INT_ENABLE = 8'h14;
   localparam logic [7:0] OFF_PIN_CFG    = 8'h18;
   // Control field positions
   localparam int unsigned CTRL_PRESCALE_LSB = 0;
   localparam int unsigned CTRL_PRESCALE_MSB = 2;
   localparam int unsigned CTRL_EDGE_BIT     = 3;
   localparam int unsigned CTRL_RUN_BIT      = 4;
   localparam int unsigned CTRL_MODE_LSB     = 6;
   localparam int unsigned CTRL_MODE_MSB     = 7;
   // Interrupt, pin config and HTRANS bit positions
   localparam int unsigned INT_OVERFLOW_BIT   = 0;
   localparam int unsigned INT_PULSE_DONE_BIT = 1;
   localparam int unsigned PIN_PULL_HIGH_BIT  = 0;
   localparam int unsigned HTRANS_ACTIVE_BIT  = 1;
   // Reset values
   localparam logic [PRESCALE_W-1:0] PRESCALE_RESET   = 3'h0;
   localparam logic [INT_W-1:0]      INT_RESET        = 2'h0;
   localparam logic [31:0]           HRDATA_RESET     = 32'h0000_0000;
   localparam logic                  HRESP_OKAY       = 1'b0;
   typedef enum logic [1:0] {
      MODE_OFF   = 2'b00,
      MODE_EVENT = 2'b01,
      MODE_TIMER = 2'b10,
      MODE_PULSE = 2'b11
   } operating_mode_t;
   typedef enum logic [1:0] {
      PW_IDLE  = 2'b00,
      PW_ARMED = 2'b01,
      PW_COUNT = 2'b11
   } pulse_state_t;
endpackage : timer_pkg
`default_nettype wire

/* src/timer_event_counter.sv */
`default_nettype none
module timer_event_counter
   import timer_pkg::*;
#(
   parameter int unsigned COUNT_W = COUNT_W_DEFAULT
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Shared timer pin and system state
   input  wire logic        port_a_line_two,
   input  wire logic        power_down,
   // Outputs to core and pad
   output logic             irq,
   output logic             wake_up,
   output logic             pull_high_en
);

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
      reg_hit = (addr == off);
   endfunction

   function automatic logic [DIV_W-1:0] prescale_mask(input logic [PRESCALE_W-1:0] sel);
      prescale_mask = DIV_W'((8'h01 << sel) - 8'h01);
   endfunction

   logic                  dp_valid;
   logic                  dp_write;
   logic [7:0]            dp_addr;
   logic                  wr;
   logic                  wr_ctrl;
   logic                  wr_pre;
   logic                  wr_clear;
   logic                  wr_enable;
   logic                  wr_pin;
   logic                  rd_take;
   logic [31:0]           next_rdata;

   logic [PRESCALE_W-1:0] prescale_select;
   logic                  active_edge_select;
   logic                  counter_run_bit;
   operating_mode_t       operating_mode_pair;
   logic [COUNT_W-1:0]    preload;
   logic [COUNT_W-1:0]    count;
   logic [INT_W-1:0]      int_status;
   logic [INT_W-1:0]      int_enable;
   logic [INT_W-1:0]      next_status;
   logic [INT_W-1:0]      next_enable;
   logic                  pull_high_cfg;

   logic [DIV_W-1:0]      div;
   logic                  tick;
   logic                  pin_prev;
   logic                  rise;
   logic                  fall;
   logic                  event_edge;
   logic                  start_edge;
   logic                  end_edge;
   pulse_state_t          pw_state;
   logic                  pulse_end;
   logic                  count_step;
   logic                  overflow;

   // Bus data phase; zero wait states, so the slave is never busy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr  <= 8'h00;
      end else if (hready) begin
         dp_valid <= hsel && htrans[HTRANS_ACTIVE_BIT];
         dp_write <= hwrite;
         dp_addr  <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

   assign wr        = dp_valid && dp_write;
   assign wr_ctrl   = wr && reg_hit(dp_addr, OFF_CTRL);
   assign wr_pre    = wr && reg_hit(dp_addr, OFF_PRELOAD);
   assign wr_clear  = wr && reg_hit(dp_addr, OFF_INT_CLEAR);
   assign wr_enable = wr && reg_hit(dp_addr, OFF_INT_ENABLE);
   assign wr_pin    = wr && reg_hit(dp_addr, OFF_PIN_CFG);
   assign rd_take   = hsel && hready && htrans[HTRANS_ACTIVE_BIT] && !hwrite;

   // Read data is sampled in the address phase so it stands for the data phase
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_hit(haddr[7:0], OFF_CTRL)) begin
         next_rdata[CTRL_MODE_MSB:CTRL_MODE_LSB]         = operating_mode_pair;
         next_rdata[CTRL_RUN_BIT]                        = counter_run_bit;
         next_rdata[CTRL_EDGE_BIT]                       = active_edge_select;
         next_rdata[CTRL_PRESCALE_MSB:CTRL_PRESCALE_LSB] = prescale_select;
      end else if (reg_hit(haddr[7:0], OFF_PRELOAD)) begin
         next_rdata[COUNT_W-1:0] = preload;
      end else if (reg_hit(haddr[7:0], OFF_COUNT)) begin
         next_rdata[COUNT_W-1:0] = count;
      end else if (reg_hit(haddr[7:0], OFF_INT_STATUS)) begin
         next_rdata[INT_W-1:0] = int_status;
      end else if (reg_hit(haddr[7:0], OFF_INT_ENABLE)) begin
         next_rdata[INT_W-1:0] = int_enable;
      end else if (reg_hit(haddr[7:0], OFF_PIN_CFG)) begin
         next_rdata[PIN_PULL_HIGH_BIT] = pull_high_cfg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= HRDATA_RESET;
      end else if (rd_take) begin
         hrdata <= next_rdata;
      end
   end

   // Control register; software write wins over the hardware clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prescale_select     <= PRESCALE_RESET;
         active_edge_select  <= 1'b0;
         counter_run_bit     <= 1'b0;
         operating_mode_pair <= MODE_OFF;
      end else if (wr_ctrl) begin
         prescale_select     <= hwdata[CTRL_PRESCALE_MSB:CTRL_PRESCALE_LSB];
         active_edge_select  <= hwdata[CTRL_EDGE_BIT];
         counter_run_bit     <= hwdata[CTRL_RUN_BIT];
         operating_mode_pair <=
            operating_mode_t'(hwdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
      end else if (pulse_end) begin
         counter_run_bit <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pull_high_cfg <= 1'b0;
         pull_high_en  <= 1'b0;
      end else begin
         if (wr_pin) begin
            pull_high_cfg <= hwdata[PIN_PULL_HIGH_BIT];
         end
         // Mode does not gate the pull-high
         pull_high_en <= pull_high_cfg;
      end
   end

   // Free-running prescaler; ratio is 2 to the power prescale_select
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div <= '0;
      end else begin
         div <= div + 1'b1;
      end
   end

   assign tick = (div & prescale_mask(prescale_select))
                 == prescale_mask(prescale_select);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= port_a_line_two;
      end
   end

   // Only transitions matter, never the pin level
   assign rise       = port_a_line_two && !pin_prev;
   assign fall       = !port_a_line_two && pin_prev;
   assign event_edge = active_edge_select ? fall : rise;
   assign start_edge = active_edge_select ? rise : fall;
   assign end_edge   = event_edge;

   assign pulse_end = (operating_mode_pair == MODE_PULSE) && counter_run_bit
                      && (pw_state == PW_COUNT) && end_edge;

   // Pulse measurement: armed by run bit, counts between edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pw_state <= PW_IDLE;
      end else if (operating_mode_pair != MODE_PULSE || !counter_run_bit) begin
         pw_state <= PW_IDLE;
      end else begin
         unique case (pw_state)
            PW_IDLE:  pw_state <= start_edge ? PW_COUNT : PW_ARMED;
            PW_ARMED: pw_state <= start_edge ? PW_COUNT : PW_ARMED;
            PW_COUNT: pw_state <= end_edge ? PW_IDLE : PW_COUNT;
            default:  pw_state <= PW_IDLE;
         endcase
      end
   end

   always_comb begin
      count_step = 1'b0;
      unique case (operating_mode_pair)
         MODE_TIMER: count_step = counter_run_bit && tick;
         // No prescaler and no power-down gating in event mode
         MODE_EVENT: count_step = counter_run_bit && event_edge;
         MODE_PULSE: count_step = counter_run_bit && (pw_state == PW_COUNT)
                                  && tick && !end_edge;
         MODE_OFF:   count_step = 1'b0;
      endcase
   end

   assign overflow = count_step && (count == '1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         preload <= '0;
      end else if (wr_pre) begin
         preload <= hwdata[COUNT_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= '0;
      end else if (wr_pre && !counter_run_bit) begin
         count <= hwdata[COUNT_W-1:0];
      end else if (overflow) begin
         count <= preload;
      end else if (count_step) begin
         count <= count + 1'b1;
      end
   end

   // Sticky status; a new event beats a clear in the same cycle
   always_comb begin
      next_status = int_status;
      if (wr_clear) begin
         next_status = int_status & ~hwdata[INT_W-1:0];
      end
      next_status[INT_OVERFLOW_BIT]   = next_status[INT_OVERFLOW_BIT] | overflow;
      next_status[INT_PULSE_DONE_BIT] = next_status[INT_PULSE_DONE_BIT] | pulse_end;
      next_enable = wr_enable ? hwdata[INT_W-1:0] : int_enable;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_status <= INT_RESET;
         int_enable <= INT_RESET;
         irq        <= 1'b0;
      end else begin
         int_status <= next_status;
         int_enable <= next_enable;
         irq        <= |(next_status & next_enable);
      end
   end

   // Wake-up ignores the interrupt enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_up <= 1'b0;
      end else begin
         wake_up <= overflow && power_down;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_timer_step;
      (operating_mode_pair == MODE_TIMER) && counter_run_bit && tick && (count != '1)
         |=> count == COUNT_W'($past(count) + 1'b1);
   endproperty
   a_timer_step: assert property (p_timer_step) else $error("timer tick did not count");

   property p_stopped_hold;
      !counter_run_bit && !wr_pre |=> $stable(count);
   endproperty
   a_stopped_hold: assert property (p_stopped_hold) else $error("stopped counter moved");

   property p_overflow_reload;
      overflow |=> (count == $past(preload)) && int_status[INT_OVERFLOW_BIT];
   endproperty
   a_overflow_reload: assert property (p_overflow_reload) else $error("bad reload");

   property p_irq_gate;
      irq == (|(int_status & int_enable));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enable");

   property p_event_no_prescale;
      (operating_mode_pair == MODE_EVENT) && counter_run_bit && event_edge && (count != '1)
         |=> count == COUNT_W'($past(count) + 1'b1);
   endproperty
   a_event_no_prescale: assert property (p_event_no_prescale) else $error("edge lost");

   property p_event_wrong_edge;
      (operating_mode_pair == MODE_EVENT) && !active_edge_select && fall && !wr_pre
         |=> $stable(count);
   endproperty
   a_event_wrong_edge: assert property (p_event_wrong_edge) else $error("fall counted");

   property p_wake;
      overflow && power_down |=> wake_up ##1 (wake_up == $past(overflow && power_down));
   endproperty
   a_wake: assert property (p_wake) else $error("no wake-up on overflow");

   property p_arm_wait;
      (operating_mode_pair == MODE_PULSE) && (pw_state != PW_COUNT) |-> !count_step;
   endproperty
   a_arm_wait: assert property (p_arm_wait) else $error("counted before start edge");

   property p_pulse_stop_low;
      pulse_end && !active_edge_select && !wr_ctrl
         |=> !counter_run_bit && $stable(count) ##1 ($stable(count) || $past(wr_pre));
   endproperty
   a_pulse_stop_low: assert property (p_pulse_stop_low) else $error("no stop on rise");

   property p_pulse_stop_high;
      pulse_end && active_edge_select && !wr_ctrl |=> !counter_run_bit && (pw_state == PW_IDLE);
   endproperty
   a_pulse_stop_high: assert property (p_pulse_stop_high) else $error("no fall stop");

   property p_no_hw_clear;
      counter_run_bit && (operating_mode_pair != MODE_PULSE) && !wr_ctrl |=> counter_run_bit;
   endproperty
   a_no_hw_clear: assert property (p_no_hw_clear) else $error("run bit cleared");

   property p_preload_direct;
      wr_pre && !counter_run_bit |=> count == $past(hwdata[COUNT_W-1:0]);
   endproperty
   a_preload_direct: assert property (p_preload_direct) else $error("no direct load");

   property p_done_idle;
      (operating_mode_pair == MODE_PULSE) && !counter_run_bit |=> pw_state == PW_IDLE;
   endproperty
   a_done_idle: assert property (p_done_idle) else $error("edge after stop");

   property p_level_no_start;
      (operating_mode_pair == MODE_PULSE) && counter_run_bit && (pw_state == PW_ARMED)
         && !start_edge |=> pw_state == PW_ARMED;
   endproperty
   a_level_no_start: assert property (p_level_no_start) else $error("level start");

   property p_start_fall;
      (operating_mode_pair == MODE_PULSE) && counter_run_bit && !active_edge_select
         && fall && (pw_state != PW_COUNT) |=> pw_state == PW_COUNT;
   endproperty
   a_start_fall: assert property (p_start_fall) else $error("fall did not start");

   property p_start_rise;
      (operating_mode_pair == MODE_PULSE) && counter_run_bit && active_edge_select
         && rise && (pw_state != PW_COUNT) |=> pw_state == PW_COUNT;
   endproperty
   a_start_rise: assert property (p_start_rise) else $error("rise did not start");

   property p_pull_follow;
      pull_high_en == $past(pull_high_cfg);
   endproperty
   a_pull_follow: assert property (p_pull_follow) else $error("pull-high lost");

   property p_count_up;
      count_step && (count != '1) |=> count == COUNT_W'($past(count) + 1'b1);
   endproperty
   a_count_up: assert property (p_count_up) else $error("step not plus one");

   c_timer_overflow: cover property ((operating_mode_pair == MODE_TIMER) && overflow);
   c_event_wake: cover property ((operating_mode_pair == MODE_EVENT) && overflow && power_down);
   c_pulse_done: cover property (pulse_end ##1 !counter_run_bit);
   c_irq: cover property (!irq ##1 irq);

endmodule // timer_event_counter
`default_nettype wire

/* sim/pulse_source.sv */
`default_nettype none
module pulse_source (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Request from the bench
   input  wire logic       go,
   input  wire logic       idle_lvl,
   input  wire logic [7:0] n_pulse,
   input  wire logic [7:0] width,
   // Pin side
   output logic            pin,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] left;
   logic [7:0] hold;
   // Pin is assumed set as input; each level held width cycles, one edge a cycle at most
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin  <= 1'b0;
         busy <= 1'b0;
         left <= 9'h000;
         hold <= 8'h00;
      end else if (go) begin
         busy <= 1'b1;
         left <= {n_pulse, 1'b0};
         hold <= width;
         pin  <= idle_lvl;
      end else if (!busy) begin
         pin <= idle_lvl;
      end else if (hold != 8'h00) begin
         hold <= hold - 8'h01;
      end else if (left != 9'h000) begin
         pin  <= ~pin;
         left <= left - 9'h001;
         hold <= width - 8'h01;
      end else begin
         busy <= 1'b0;
      end
   end
endmodule // pulse_source
`default_nettype wire

/* sim/timer_event_counter_modes_tb.sv */
`default_nettype none
module timer_event_counter_modes_tb;
   import timer_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LIMIT = 20000;
   typedef struct {string nm; logic [31:0] v;} note_t;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        pin, power_down, irq, wake_up, pull_high_en;
   logic        go, idle, busy, rd_phase;
   logic [7:0]  npul, wid, p, w;
   logic [15:0] r;
   int          err_count, checked, cyc, n;
   int          wake_t[$];
   note_t       exp_q[$];

   timer_event_counter dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .port_a_line_two(pin),
      .power_down(power_down), .irq(irq), .wake_up(wake_up), .pull_high_en(pull_high_en));
   pulse_source src (.hclk(hclk), .hresetn(hresetn), .go(go), .idle_lvl(idle),
      .n_pulse(npul), .width(wid), .pin(pin), .busy(busy));

   always #5 hclk = ~hclk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Reference count after n active edges, with reload on each overflow
   function automatic logic [15:0] ev_model(input logic [7:0] pre, input int k);
      logic [7:0] c;
      logic [7:0] ov;
      c = pre;
      ov = 8'h00;
      for (int i = 0; i < k; i++) begin
         if (c == 8'hff) begin
            c = pre;
            ov++;
         end else c++;
      end
      return {ov, c};
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Single word transfer; a read notes its expected data for the monitor
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input string nm);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      if (!wr) begin
         exp_q.push_back('{nm, d});
         rd_phase <= 1'b1;
      end
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd_phase <= 1'b0;
   endtask

   task automatic pulse(input logic [7:0] k, input logic [7:0] wd);
      npul <= k;
      wid  <= wd;
      go   <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      @(posedge hclk);
      while (busy) @(posedge hclk);
      repeat (4) @(posedge hclk);
   endtask

   always @(posedge hclk) begin
      note_t nt;
      cyc <= cyc + 1;
      if (wake_up === 1'b1) wake_t.push_back(cyc);
      if (rd_phase === 1'b1 && hreadyout === 1'b1 && exp_q.size() > 0) begin
         nt = exp_q.pop_front();
         check(nt.nm, hrdata, nt.v);
      end
      if (cyc == LIMIT) begin
         err_count++;
         test_done();
      end
   end

   initial begin
      hclk       = 1'b0;
      hresetn    = 1'b0;
      hsel       = 1'b0;
      haddr      = 32'h0;
      htrans     = 2'h0;
      hwrite     = 1'b0;
      hsize      = 3'h2;
      hwdata     = 32'h0;
      power_down = 1'b0;
      go         = 1'b0;
      idle       = 1'b0;
      npul       = 8'h00;
      wid        = 8'h01;
      rd_phase   = 1'b0;
      seed       = 32'h2b521a4f;
      err_count  = 0;
      checked    = 0;
      cyc        = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      check("hresp", {31'h0, hresp}, 32'h0);
      bus(1'b1, 8'h1c, 32'hffff_ffff, "");
      for (int i = 0; i < 8; i++) bus(1'b0, 8'(i * 4), 32'h0, "reset_value");
      $display("Test reset done");
      // Overflow spacing gives the exact prescaled rate without read latency doubts
      power_down <= 1'b1;
      for (int s = 0; s < 4; s += 3) begin
         seed = lfsr(seed);
         p = 8'hf0 | seed[3:0];
         bus(1'b1, OFF_CTRL, 32'h0, "");
         bus(1'b1, OFF_PRELOAD, p, "");
         bus(1'b0, OFF_COUNT, p, "count_load");
         wake_t.delete();
         bus(1'b1, OFF_CTRL, 32'h90 | s, "");
         while (wake_t.size() < 3) @(posedge hclk);
         n = wake_t[2] - wake_t[1];
         check("period", n, (32'h100 - p) << s);
      end
      bus(1'b1, OFF_CTRL, 32'h0, "");
      bus(1'b0, OFF_INT_STATUS, 32'h1, "ovf_sticky");
      check("irq_masked", {31'h0, irq}, 32'h0);
      bus(1'b1, OFF_INT_ENABLE, 32'h3, "");
      repeat (2) @(posedge hclk);
      check("irq_on", {31'h0, irq}, 32'h1);
      bus(1'b1, OFF_INT_CLEAR, 32'h3, "");
      repeat (2) @(posedge hclk);
      check("irq_off", {31'h0, irq}, 32'h0);
      bus(1'b0, OFF_INT_STATUS, 32'h0, "cleared");
      $display("Test timer done");
      // Final idle change is an edge of the inactive kind and must not count
      for (int e = 0; e < 2; e++) begin
         seed = lfsr(seed);
         n = 8 + seed[3:0];
         r = ev_model(8'hf8, n);
         idle <= ~e[0];
         bus(1'b1, OFF_CTRL, 32'h0, "");
         bus(1'b1, OFF_PRELOAD, 32'hf8, "");
         wake_t.delete();
         bus(1'b1, OFF_CTRL, 32'h57 | (e << 3), "");
         pulse(8'(n), 8'h02);
         idle <= e[0];
         repeat (4) @(posedge hclk);
         bus(1'b0, OFF_COUNT, r[7:0], "ev_count");
         bus(1'b0, OFF_CTRL, 32'h57 | (e << 3), "run_kept");
         check("wakes", 32'(wake_t.size()), r[15:8]);
      end
      $display("Test event done");
      power_down <= 1'b0;
      for (int e = 0; e < 2; e++) begin
         seed = lfsr(seed);
         w = 8'h10 | seed[3:0];
         idle <= e[0];
         bus(1'b1, OFF_CTRL, 32'h0, "");
         bus(1'b1, OFF_PRELOAD, 32'h0, "");
         bus(1'b1, OFF_INT_CLEAR, 32'h3, "");
         bus(1'b1, OFF_CTRL, 32'hd0 | (e << 3), "");
         repeat (8) @(posedge hclk);
         bus(1'b0, OFF_COUNT, 32'h0, "armed_level");
         idle <= ~e[0];
         repeat (4) @(posedge hclk);
         pulse(8'h01, w);
         bus(1'b0, OFF_COUNT, w - 8'h01, "width");
         bus(1'b0, OFF_CTRL, 32'hc0 | (e << 3), "run_cleared");
         bus(1'b0, OFF_INT_STATUS, 32'h2, "done_flag");
         check("irq_done", {31'h0, irq}, 32'h1);
         pulse(8'h02, w);
         bus(1'b0, OFF_COUNT, w - 8'h01, "held");
      end
      bus(1'b1, OFF_PIN_CFG, 32'h1, "");
      repeat (2) @(posedge hclk);
      check("pull_high", {31'h0, pull_high_en}, 32'h1);
      bus(1'b0, OFF_PIN_CFG, 32'h1, "pin_cfg");
      $display("Test pulse done");
      test_done();
   end
endmodule // timer_event_counter_modes_tb
`default_nettype wire
